// *** hw/hrl_defs.svh ***
// Purpose: constants for the real-time sample and library control register slice
// Assumes: apb with 32-bit data, each register one aligned word
// Notes:   printed offsets are register indexes; byte address is four times the index
//
// Operation
// - realtime mode drives sample to actuator; resets zero
// - host rewrites sample anytime; applied without retrigger
// - sample signed by default; unsigned when format set
// - output float bit forces true high impedance
// - float only while enabled; else weak pulldown
// - output float takes effect immediately, no waiting
// - library select picks waveform library, reset one
// - mode five selects continuous realtime playback
// - standby bit six resets one; one means standby
`ifndef HRL_DEFS_SVH
`define HRL_DEFS_SVH

// ----------------------------------------------------------------
// register indexes and byte addresses
// ----------------------------------------------------------------
`define HRL_IDX_MODE        8'h01
`define HRL_IDX_SAMPLE      8'h02
`define HRL_IDX_LIBCTL      8'h03
`define HRL_IDX_FORMAT      8'h1d
`define HRL_ADDR_MODE       12'h004
`define HRL_ADDR_SAMPLE     12'h008
`define HRL_ADDR_LIBCTL     12'h00c
`define HRL_ADDR_FORMAT     12'h074

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HRL_MODE_STANDBY    6
`define HRL_LIB_FLOAT       4
`define HRL_FMT_UNSIGNED    3

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define HRL_RST_MODE        8'h40
`define HRL_RST_SAMPLE      8'h00
`define HRL_RST_LIBCTL      8'h01
`define HRL_RST_FORMAT      8'h00
`define HRL_LIBCTL_MASK     8'h17
`define HRL_MODE_MASK       8'h47
`define HRL_FORMAT_MASK     8'h08
`define HRL_MODE_REALTIME   3'h5
`define HRL_MODE_INTERNAL   3'h0

`endif

// *** hw/hrl_pkg.sv ***
// Purpose: types for the real-time sample and library control slice
// Assumes: nothing beyond the defs header
// Notes:   library codes follow the control register field
package hrl_pkg;

  // ----------------------------------------------------------------
  // waveform library choice
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HRL_LIB_EMPTY    = 3'h0,
    HRL_LIB_A        = 3'h1,
    HRL_LIB_B        = 3'h2,
    HRL_LIB_C        = 3'h3,
    HRL_LIB_D        = 3'h4,
    HRL_LIB_E        = 3'h5,
    HRL_LIB_RESONANT = 3'h6,
    HRL_LIB_F        = 3'h7
  } hrl_lib_t;

  // ----------------------------------------------------------------
  // output stage condition
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HRL_OUT_PULLDOWN = 3'b001,
    HRL_OUT_DRIVE    = 3'b010,
    HRL_OUT_FLOAT    = 3'b100
  } hrl_out_t;

endpackage : hrl_pkg

// *** hw/hrl_out_stage.sv ***
// Purpose: output stage condition and drive level from the realtime sample
// Assumes: called every cycle from the register slice
// Notes:   float overrides drive at once; disabled device holds pulldown
`timescale 1ns/1ps
`include "hrl_defs.svh"
module hrl_out_stage (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [7:0]        sample,
  input  wire logic              fmt_unsigned,
  input  wire logic [2:0]        mode,
  input  wire logic              standby,
  input  wire logic              shutdown_n,
  input  wire logic              float_req,
  output hrl_pkg::hrl_out_t      out_state,
  output logic signed [8:0]      drive_level
);
  import hrl_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire              enabled_w  = shutdown_n & ~standby;
  wire              realtime_w = enabled_w & (mode == `HRL_MODE_REALTIME);
  wire signed [8:0] signed_w   = {sample[7], sample};
  wire signed [8:0] unsigned_w = $signed({1'b0, sample}) - $signed(9'h080);
  wire signed [8:0] level_w    = realtime_w ? (fmt_unsigned ? unsigned_w : signed_w) : 9'sh000;

  hrl_out_t state_d;
  always_comb begin
    if (!enabled_w) begin
      state_d = HRL_OUT_PULLDOWN;
    end else if (float_req) begin
      state_d = HRL_OUT_FLOAT;
    end else begin
      state_d = HRL_OUT_DRIVE;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_state   <= HRL_OUT_PULLDOWN;
      drive_level <= 9'sh000;
    end else begin
      out_state   <= state_d;
      drive_level <= level_w;
    end
  end

  case (1'b1)
    default: begin : g_chk
      float_now_a: assert property (@(posedge pclk) disable iff (!presetn)
        (enabled_w && float_req) |=> (out_state == HRL_OUT_FLOAT))
        else $error("float not applied next cycle");
      pull_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !enabled_w |=> (out_state == HRL_OUT_PULLDOWN))
        else $error("disabled device not in pulldown");
      sign_fmt_a: assert property (@(posedge pclk) disable iff (!presetn)
        (realtime_w && !fmt_unsigned) |=> (drive_level == $signed({$past(sample[7]), $past(sample)})))
        else $error("signed sample level wrong");
      idle_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode != `HRL_MODE_REALTIME) |=> (drive_level == 9'sh000))
        else $error("level driven outside realtime mode");
    end
  endcase

endmodule : hrl_out_stage

// *** hw/hrl_regs.sv ***
// Purpose: apb register slice for realtime sample, mode, library control, format
// Assumes: apb slave answers with zero wait states
// Notes:   unmapped addresses read zero and raise pslverr
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "hrl_defs.svh"
module hrl_regs (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              shutdown_n,
  output hrl_pkg::hrl_lib_t      library_sel,
  output hrl_pkg::hrl_out_t      out_state,
  output logic signed [8:0]      drive_level,
  output logic                   output_float
);
  import hrl_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] mode_q,   mode_d;
  logic [7:0] sample_q, sample_d;
  logic [7:0] libctl_q, libctl_d;
  logic [7:0] format_q, format_d;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire        access_w  = psel & penable;
  wire        wr_w      = access_w & pwrite & pstrb[0];
  wire        hit_mode  = (paddr == `HRL_ADDR_MODE);
  wire        hit_samp  = (paddr == `HRL_ADDR_SAMPLE);
  wire        hit_lib   = (paddr == `HRL_ADDR_LIBCTL);
  wire        hit_fmt   = (paddr == `HRL_ADDR_FORMAT);
  wire        mapped_w  = hit_mode | hit_samp | hit_lib | hit_fmt;
  wire [7:0]  wbyte     = pwdata[7:0];
  wire [7:0]  rd_byte_w = hit_mode ? mode_q :
                          hit_samp ? sample_q :
                          hit_lib  ? libctl_q :
                          hit_fmt  ? format_q : 8'h00;

  assign mode_d   = (wr_w && hit_mode) ? (wbyte & `HRL_MODE_MASK)   : mode_q;
  assign sample_d = (wr_w && hit_samp) ? wbyte                      : sample_q;
  assign libctl_d = (wr_w && hit_lib)  ? (wbyte & `HRL_LIBCTL_MASK) : libctl_q;
  assign format_d = (wr_w && hit_fmt)  ? (wbyte & `HRL_FORMAT_MASK) : format_q;

  assign pready       = 1'b1;
  assign pslverr      = access_w & ~mapped_w;
  assign prdata       = {24'h000000, rd_byte_w};
  assign library_sel  = hrl_lib_t'(libctl_q[2:0]);
  assign output_float = libctl_q[`HRL_LIB_FLOAT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= `HRL_RST_MODE;
      sample_q <= `HRL_RST_SAMPLE;
      libctl_q <= `HRL_RST_LIBCTL;
      format_q <= `HRL_RST_FORMAT;
    end else begin
      mode_q   <= mode_d;
      sample_q <= sample_d;
      libctl_q <= libctl_d;
      format_q <= format_d;
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  hrl_out_stage u_out (
    .pclk         (pclk),
    .presetn      (presetn),
    .sample       (sample_q),
    .fmt_unsigned (format_q[`HRL_FMT_UNSIGNED]),
    .mode         (mode_q[2:0]),
    .standby      (mode_q[`HRL_MODE_STANDBY]),
    .shutdown_n   (shutdown_n),
    .float_req    (libctl_q[`HRL_LIB_FLOAT]),
    .out_state    (out_state),
    .drive_level  (drive_level)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence samp_write_s;
    wr_w && hit_samp;
  endsequence

  samp_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    samp_write_s |=> (sample_q == $past(pwdata[7:0])))
    else $error("sample write not stored");
  res_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (libctl_q & 8'he8) == 8'h00)
    else $error("reserved control bits nonzero");
  lib_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_w && hit_lib) |=> (library_sel == hrl_lib_t'($past(pwdata[2:0]))))
    else $error("library select not updated");
  float_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_w && hit_lib && pwdata[4] && shutdown_n && !mode_q[6])
      |=> ##1 (out_state == HRL_OUT_FLOAT))
    else $error("float bit did not float output");
  standby_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_w && hit_mode && pwdata[6]) |=> mode_q[6] ##1 (out_state == HRL_OUT_PULLDOWN))
    else $error("standby not entered");
  rt_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q[2:0] == `HRL_MODE_REALTIME && !mode_q[6] && shutdown_n && format_q[3])
      |=> (drive_level == $signed({1'b0, $past(sample_q)}) - $signed(9'h080)))
    else $error("realtime level wrong");

endmodule : hrl_regs

// *** verif/hrl_host_model.sv ***
// Purpose: apb host model writing and reading the sample and control registers
// Assumes: one clock, slave may add wait states
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
module hrl_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0;
  end
  // ----------------------------------------------------------------
  // one apb transfer; sample rewrites and register reads go through here
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0; paddr <= ~a; pwdata <= ~d;
  endtask : xfer
endmodule : hrl_host_model

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the sample and library control slice
// Assumes: zero wait apb, outputs settle two edges after a write
// Notes:   expected values come from the register map and level mapping
`timescale 1ns/1ps
`include "hrl_defs.svh"
module tb_top;
  import hrl_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, shutdown_n = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, output_float;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  hrl_lib_t    library_sel;
  hrl_out_t    out_state;
  logic signed [8:0] drive_level;
  logic e;
  int mismatches = 0, comparisons = 0;
  always #4 pclk = ~pclk;
  hrl_host_model host_u (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  hrl_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_n(shutdown_n), .library_sel(library_sel), .out_state(out_state),
    .drive_level(drive_level), .output_float(output_float));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, {24'h0, d}, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    host_u.xfer(1'b0, a, 32'h0, r, e);
    chk("read", r, {24'h0, x});
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  task automatic chk_st(input hrl_out_t s);
    chk("state", {29'h0, out_state}, {29'h0, s});
  endtask : chk_st
  task automatic chk_lvl(input logic [8:0] l);
    chk("level", {23'h0, drive_level}, {23'h0, l});
  endtask : chk_lvl
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`HRL_ADDR_LIBCTL, 8'h01);
    rd(`HRL_ADDR_SAMPLE, 8'h00);
    rd(`HRL_ADDR_MODE, 8'h40);
    chk_st(HRL_OUT_PULLDOWN);
    wr(`HRL_ADDR_LIBCTL, 8'hff);
    rd(`HRL_ADDR_LIBCTL, 8'h17);
    for (int i = 0; i < 8; i++) begin
      wr(`HRL_ADDR_LIBCTL, 8'(i));
      settle;
      chk("lib", {29'h0, library_sel}, 32'(i));
    end
    wr(`HRL_ADDR_MODE, 8'h05);
    wr(`HRL_ADDR_SAMPLE, 8'h80);
    settle;
    chk_st(HRL_OUT_DRIVE);
    chk_lvl(9'h180);
    wr(`HRL_ADDR_SAMPLE, 8'h7f);
    settle;
    chk_lvl(9'h07f);
    wr(`HRL_ADDR_FORMAT, 8'h08);
    settle;
    chk_lvl(9'h1ff);
    wr(`HRL_ADDR_SAMPLE, 8'hff);
    settle;
    chk_lvl(9'h07f);
    wr(`HRL_ADDR_LIBCTL, 8'h11);
    settle;
    chk("float", {31'h0, output_float}, 32'h1);
    chk_st(HRL_OUT_FLOAT);
    @(posedge pclk);
    shutdown_n <= 1'b0;
    settle;
    chk_st(HRL_OUT_PULLDOWN);
    @(posedge pclk);
    shutdown_n <= 1'b1;
    wr(`HRL_ADDR_MODE, 8'h45);
    settle;
    chk_st(HRL_OUT_PULLDOWN);
    wr(`HRL_ADDR_MODE, 8'h00);
    settle;
    chk_lvl(9'h000);
    host_u.xfer(1'b0, 12'h100, 32'h0, r, e);
    chk("unmapped", r, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    give_verdict;
  end
endmodule : tb_top
